// file: scb_chk.sv
`timescale 1ns/1ps
module scb_chk
  import scb_pkg::*;
(
  // Clock and reset
  input wire logic                  clk_sys_i,
  input wire logic                  rst_b_i,
  // Watched inputs
  input wire logic                  sen_n_i,
  input wire logic                  power_down_pin_n_i,
  input wire logic                  lock_detect_n_i,
  // Watched outputs
  input wire scb_pkg::scb_ctrl_t    ctrl_o,
  input wire logic [SCB_DATA_W-1:0] rf1_divide_ratio_o,
  input wire logic [SCB_RF2_W-1:0]  rf2_divide_ratio_o,
  input wire logic [SCB_IF_W-1:0]   if_divide_ratio_o
);
  // One clock domain for all properties
  default clocking cb @(posedge clk_sys_i);
  endclocking
  default disable iff (!rst_b_i);

  // Pin low forces both sections off
  a_pin_if_off: assert property (!power_down_pin_n_i [*6] |-> !ctrl_o.if_on)
    else $error("IF section on while power pin low");
  a_pin_rf_off: assert property (!power_down_pin_n_i [*6] |-> !ctrl_o.rf_on)
    else $error("RF section on while power pin low");
  // Reference amplifier follows either section
  a_ref_amp_or: assert property (ctrl_o.ref_amp_on == (ctrl_o.if_on | ctrl_o.rf_on))
    else $error("Reference amplifier state wrong");
  // Both legal aux codes give low while lock signal is low
  a_aux_lock_low: assert property (!lock_detect_n_i [*6] |-> !ctrl_o.aux_output_pin)
    else $error("Aux pin high while lock signal low");
  // Divide ratios and low power bit hold while a word is still arriving
  a_rf1_hold: assert property (!sen_n_i [*8] |-> $stable(rf1_divide_ratio_o))
    else $error("RF1 ratio moved mid word");
  a_rf2_hold: assert property (!sen_n_i [*8] |-> $stable(rf2_divide_ratio_o))
    else $error("RF2 ratio moved mid word");
  a_if_div_hold: assert property (!sen_n_i [*8] |-> $stable(if_divide_ratio_o))
    else $error("IF ratio moved mid word");
  a_low_pwr_hold: assert property (!sen_n_i [*8] |-> $stable(ctrl_o.if_output_low_power))
    else $error("Low power bit moved mid word");

  // Main scenarios reached
  c_both_on: cover property (ctrl_o.if_on && ctrl_o.rf_on);
  c_aux_high: cover property (ctrl_o.aux_output_pin);
  c_rf1_load: cover property ($changed(rf1_divide_ratio_o));
endmodule

bind scb_synth_control_register_bank scb_chk i_scb_chk (.clk_sys_i, .rst_b_i, .sen_n_i,
  .power_down_pin_n_i, .lock_detect_n_i, .ctrl_o, .rf1_divide_ratio_o, .rf2_divide_ratio_o,
  .if_divide_ratio_o);

// file: scb_host.sv
`timescale 1ns/1ps
module scb_host (
  // Clock
  input  wire logic clk_sys_i,
  // Serial port drive
  output logic      sclk_i,
  output logic      sdata_i,
  output logic      sen_n_i
);
  // Idle: clock still, port deselected
  initial begin
    sclk_i  = 1'b0;
    sdata_i = 1'b0;
    sen_n_i = 1'b1;
  end

  // Send n bits of w MSB first, 5 clk per phase, 14 clk gap after
  task automatic send(input logic [21:0] w, input int n);
    @(posedge clk_sys_i);
    #1 sen_n_i = 1'b0;
    for (int i = 21; i > 21 - n; i--) begin
      sdata_i = w[i];
      repeat (5) @(posedge clk_sys_i);
      #1 sclk_i = 1'b1;
      repeat (5) @(posedge clk_sys_i);
      #1 sclk_i = 1'b0;
    end
    repeat (5) @(posedge clk_sys_i);
    #1 sen_n_i = 1'b1;
    sdata_i = ~sdata_i; // Released line parks on the inverse
    repeat (14) @(posedge clk_sys_i);
  endtask
endmodule

// file: scb_pkg.sv
package scb_pkg;

  // Word layout of one serial write
  localparam int SCB_DATA_W    = 18;
  localparam int SCB_ADDR_W    = 4;
  localparam int SCB_WORD_W    = SCB_DATA_W + SCB_ADDR_W;

  // Register addresses
  localparam logic [3:0] SCB_ADDR_MAIN = 4'h0;
  localparam logic [3:0] SCB_ADDR_PDN  = 4'h2;
  localparam logic [3:0] SCB_ADDR_RF1  = 4'h3;
  localparam logic [3:0] SCB_ADDR_RF2  = 4'h4;
  localparam logic [3:0] SCB_ADDR_IF   = 4'h5;

  // Main and power-down register field positions, divider widths
  localparam int SCB_AUX_OUTPUT_SELECT_LSB = 12;
  localparam int SCB_LOWPWR_BIT = 5;
  localparam int SCB_AUTOPU_BIT = 3;
  localparam int SCB_IFEN_BIT   = 1;
  localparam int SCB_RFEN_BIT   = 0;
  localparam int SCB_RF2_W      = 17;
  localparam int SCB_IF_W       = 16;

  // Aux select codes
  localparam logic [1:0] SCB_AUX_LOW  = 2'h1;
  localparam logic [1:0] SCB_AUX_LOCK = 2'h3;

  // Values after reset
  localparam logic [1:0]  SCB_AUX_OUTPUT_SELECT_RST = 2'h1;
  localparam logic [17:0] SCB_DIV_RST    = 18'h0_0000;

  // Serial port states
  typedef enum logic [1:0] {
    SCB_IDLE  = 2'b00,
    SCB_SHIFT = 2'b01,
    SCB_DONE  = 2'b10
  } scb_state_t;

  // One received word
  typedef struct packed {
    logic [3:0]  addr;
    logic [17:0] data;
  } scb_word_t;

  // Power and aux outputs
  typedef struct packed {
    logic if_on;
    logic rf_on;
    logic ref_amp_on;
    logic if_output_low_power;
    logic aux_output_pin;
  } scb_ctrl_t;

endpackage

// file: scb_serial_rx.sv
`timescale 1ns/1ps
module scb_serial_rx
  import scb_pkg::*;
(
  // Clock and reset
  input  wire logic      clk_sys_i,
  input  wire logic      rst_b_i,
  // Synchronised serial levels
  input  wire logic      sclk_i,
  input  wire logic      sdata_i,
  input  wire logic      sen_n_i,
  // Received word
  output scb_pkg::scb_word_t word_o,
  output logic           word_vld_o
);
  typedef struct packed {
    scb_state_t             state;
    logic [SCB_WORD_W-1:0]  shreg;
    logic [4:0]             cnt;
    logic                   sclk_prev;
    logic                   vld;
    scb_word_t              word;
  } scb_rx_st_t;

  scb_rx_st_t st_q;
  scb_rx_st_t st_d;

  // Shift on rising serial clock while enabled; latch on enable rise
  always_comb begin
    st_d           = st_q;
    st_d.sclk_prev = sclk_i;
    st_d.vld       = 1'b0;
    case (st_q.state)
      SCB_IDLE: begin
        st_d.cnt = '0;
        if (!sen_n_i) begin
          st_d.state = SCB_SHIFT;
        end
      end
      SCB_SHIFT: begin
        if (sclk_i && !st_q.sclk_prev) begin
          st_d.shreg = {st_q.shreg[SCB_WORD_W-2:0], sdata_i};
          if (st_q.cnt != 5'(SCB_WORD_W + 1)) begin
            st_d.cnt = st_q.cnt + 5'h1;
          end
        end
        if (sen_n_i) begin
          st_d.state = SCB_DONE;
        end
      end
      SCB_DONE: begin
        // Only exactly one full word counts
        if (st_q.cnt == 5'(SCB_WORD_W)) begin
          st_d.word = st_q.shreg;
          st_d.vld  = 1'b1;
        end
        st_d.state = SCB_IDLE;
      end
      default: begin
        st_d.state = SCB_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  assign word_o     = st_q.word;
  assign word_vld_o = st_q.vld;
endmodule

// file: scb_sync.sv
`timescale 1ns/1ps
module scb_sync #(
  parameter int WIDTH = 4
) (
  // Clock and reset
  input  wire logic             clk_sys_i,
  input  wire logic             rst_b_i,
  // Raw and filtered levels
  input  wire logic [WIDTH-1:0] async_i,
  output logic      [WIDTH-1:0] level_o
);
  typedef struct packed {
    logic [WIDTH-1:0] s1;
    logic [WIDTH-1:0] s2;
    logic [WIDTH-1:0] s3;
    logic [WIDTH-1:0] lvl;
  } scb_sync_st_t;

  scb_sync_st_t st_q;
  scb_sync_st_t st_d;

  // Elaboration check: at least one lane
  if (WIDTH < 1) begin : g_width_check
    $error("scb_sync: WIDTH must be positive");
  end

  // Three stages; level moves once stages two and three agree
  always_comb begin
    st_d    = st_q;
    st_d.s1 = async_i;
    st_d.s2 = st_q.s1;
    st_d.s3 = st_q.s2;
    for (int i = 0; i < WIDTH; i++) begin
      if (st_q.s2[i] == st_q.s3[i]) begin
        st_d.lvl[i] = st_q.s3[i];
      end
    end
  end

  always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  assign level_o = st_q.lvl;
endmodule

// file: scb_synth_control_register_bank.sv
`timescale 1ns/1ps
module scb_synth_control_register_bank
  import scb_pkg::*;
(
  // Clock and reset
  input  wire logic                    clk_sys_i,
  input  wire logic                    rst_b_i,
  // Serial port pins
  input  wire logic                    sclk_i,
  input  wire logic                    sdata_i,
  input  wire logic                    sen_n_i,
  // Device pins and status
  input  wire logic                    power_down_pin_n_i,
  input  wire logic                    lock_detect_n_i,
  // Control outputs
  output scb_pkg::scb_ctrl_t           ctrl_o,
  output logic [SCB_DATA_W-1:0]        rf1_divide_ratio_o,
  output logic [SCB_RF2_W-1:0]         rf2_divide_ratio_o,
  output logic [SCB_IF_W-1:0]          if_divide_ratio_o
);
  import scb_pkg::*;

  typedef struct packed {
    logic [1:0]            aux_output_select;
    logic                  if_output_low_power;
    logic                  auto_power_up_all;
    logic                  if_synth_enable;
    logic                  rf_synth_enable;
    logic [SCB_DATA_W-1:0] rf1_divide_ratio;
    logic [SCB_RF2_W-1:0]  rf2_divide_ratio;
    logic [SCB_IF_W-1:0]   if_divide_ratio;
    scb_ctrl_t             ctrl;
  } scb_bank_st_t;

  scb_bank_st_t st_q;
  scb_bank_st_t st_d;
  logic [3:0]   pins_sync;
  scb_word_t    word;
  logic         word_vld;

  // Pin synchronisers; enable enters inverted so a cleared stage reads deselected
  scb_sync #(.WIDTH(4)) u_sync (
    .clk_sys_i (clk_sys_i),
    .rst_b_i   (rst_b_i),
    .async_i   ({sclk_i, sdata_i, ~sen_n_i, power_down_pin_n_i}),
    .level_o   (pins_sync)
  );

  // Serial word receiver, independent of power state
  scb_serial_rx u_rx (
    .clk_sys_i  (clk_sys_i),
    .rst_b_i    (rst_b_i),
    .sclk_i     (pins_sync[3]),
    .sdata_i    (pins_sync[2]),
    .sen_n_i    (~pins_sync[1]),
    .word_o     (word),
    .word_vld_o (word_vld)
  );

  logic [2:0] lock_sync_q;
  logic       lock_lvl_q;

  // Lock detect synchroniser, same three-stage scheme
  always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      lock_sync_q <= 3'h7;
      lock_lvl_q  <= 1'b1;
    end else begin
      lock_sync_q <= {lock_sync_q[1:0], lock_detect_n_i};
      if (lock_sync_q[1] == lock_sync_q[2]) begin
        lock_lvl_q <= lock_sync_q[2];
      end
    end
  end

  // Register writes and derived power control
  always_comb begin
    logic if_req;
    logic rf_req;
    if_req = 1'b0;
    rf_req = 1'b0;
    st_d   = st_q;
    if (word_vld) begin
      case (word.addr)
        SCB_ADDR_MAIN: begin
          st_d.aux_output_select   = word.data[SCB_AUX_OUTPUT_SELECT_LSB +: 2];
          st_d.if_output_low_power = word.data[SCB_LOWPWR_BIT];
          st_d.auto_power_up_all   = word.data[SCB_AUTOPU_BIT];
        end
        SCB_ADDR_PDN: begin
          st_d.if_synth_enable = word.data[SCB_IFEN_BIT];
          st_d.rf_synth_enable = word.data[SCB_RFEN_BIT];
        end
        SCB_ADDR_RF1: begin
          st_d.rf1_divide_ratio = word.data;
        end
        SCB_ADDR_RF2: begin
          st_d.rf2_divide_ratio = word.data[SCB_RF2_W-1:0];
        end
        SCB_ADDR_IF: begin
          st_d.if_divide_ratio = word.data[SCB_IF_W-1:0];
        end
        default: begin
          st_d = st_q; // Reserved addresses ignored
        end
      endcase
    end
    // Enables from current register values
    if_req = st_q.auto_power_up_all | st_q.if_synth_enable;
    rf_req = st_q.auto_power_up_all | st_q.rf_synth_enable;
    st_d.ctrl.if_on      = pins_sync[0] & if_req;
    st_d.ctrl.rf_on      = pins_sync[0] & rf_req;
    st_d.ctrl.ref_amp_on = pins_sync[0] & (if_req | rf_req);
    st_d.ctrl.if_output_low_power = st_q.if_output_low_power;
    // Aux pin: lock detect for code 11, else low
    st_d.ctrl.aux_output_pin =
      (st_q.aux_output_select == SCB_AUX_LOCK) ? lock_lvl_q : 1'b0;
  end

  always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      st_q                   <= '0;
      st_q.aux_output_select <= SCB_AUX_OUTPUT_SELECT_RST;
      st_q.rf1_divide_ratio  <= SCB_DIV_RST;
    end else begin
      st_q <= st_d;
    end
  end

  // Outputs straight from flip-flops
  assign ctrl_o             = st_q.ctrl;
  assign rf1_divide_ratio_o = st_q.rf1_divide_ratio;
  assign rf2_divide_ratio_o = st_q.rf2_divide_ratio;
  assign if_divide_ratio_o  = st_q.if_divide_ratio;
endmodule

// file: testbench.sv
`timescale 1ns/1ps
`define CHK(a, b) begin samples_checked++; if ((a) !== (b)) begin fail_count++; \
  $display("[FAIL] %0t got %h exp %h", $time, a, b); end end
module testbench;
  import scb_pkg::*;
  // Bench signals
  logic        clk_sys_i          = 1'b0;
  logic        rst_b_i            = 1'b0;
  logic        power_down_pin_n_i = 1'b1;
  logic        lock_detect_n_i    = 1'b1;
  logic        sclk_i;
  logic        sdata_i;
  logic        sen_n_i;
  scb_ctrl_t   ctrl_o;
  logic [17:0] rf1_divide_ratio_o;
  logic [16:0] rf2_divide_ratio_o;
  logic [15:0] if_divide_ratio_o;
  logic [31:0] seed               = 32'h1556_881d;
  logic [17:0] d;
  int          fail_count         = 0;
  int          samples_checked    = 0;
  int          cycles             = 0;
  int          m_main             = 32'h0000_1000;
  int          m_pdn              = 0;
  int          m_div[3]           = '{0, 0, 0};

  // Host model and device
  scb_host i_scb_host (.clk_sys_i, .sclk_i, .sdata_i, .sen_n_i);
  scb_synth_control_register_bank i_scb_synth_control_register_bank (.clk_sys_i, .rst_b_i,
    .sclk_i, .sdata_i, .sen_n_i, .power_down_pin_n_i, .lock_detect_n_i, .ctrl_o,
    .rf1_divide_ratio_o, .rf2_divide_ratio_o, .if_divide_ratio_o);

  // Clock and hang guard
  always #5 clk_sys_i = ~clk_sys_i;
  always @(posedge clk_sys_i) begin
    cycles++;
    if (cycles == 30000) begin
      fail_count++;
      summarize();
    end
  end

  // Xorshift source
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  // Serial write, model updated only on whole mapped words
  task automatic wr(input logic [3:0] a, input logic [17:0] v, input int n);
    i_scb_host.send({a, v}, n);
    if (n == 22) begin
      case (a)
        4'h0: m_main = v;
        4'h2: m_pdn = v;
        4'h3, 4'h4, 4'h5: m_div[a - 4'h3] = v;
        default: ;
      endcase
    end
  endtask

  // Compare every output with the model
  task automatic check();
    logic oi;
    logic orf;
    oi  = power_down_pin_n_i & (m_main[3] | m_pdn[1]);
    orf = power_down_pin_n_i & (m_main[3] | m_pdn[0]);
    `CHK(ctrl_o.if_on, oi)
    `CHK(ctrl_o.rf_on, orf)
    `CHK(ctrl_o.ref_amp_on, oi | orf)
    `CHK(ctrl_o.if_output_low_power, m_main[5])
    `CHK(ctrl_o.aux_output_pin, (m_main[13:12] == 2'b11) & lock_detect_n_i)
    `CHK(rf1_divide_ratio_o, m_div[0][17:0])
    `CHK(rf2_divide_ratio_o, m_div[1][16:0])
    `CHK(if_divide_ratio_o, m_div[2][15:0])
  endtask

  // Main sequence
  initial begin
    repeat (2) @(posedge clk_sys_i);
    #1 rst_b_i = 1'b1;
    repeat (2) @(posedge clk_sys_i);
    check();
    $display("test reset done");
    // Both aux codes, auto bit, enable pair and pin level; writes while pin low
    for (int k = 0; k < 32; k++) begin
      #1 power_down_pin_n_i = k[4];
      lock_detect_n_i = 1'(rnd());
      d = {4'h0, k[0] ? 2'b11 : 2'b01, 6'h00, 1'(rnd()), 1'b0, k[1], 3'b010};
      wr(SCB_ADDR_MAIN, d, 22);
      wr(SCB_ADDR_PDN, {16'h0000, k[3:2]}, 22);
      check();
    end
    $display("test power table done");
    // Full variant: all dividers present, all ones then random
    for (int j = 0; j < 9; j++) begin
      d = (j < 3) ? 18'h3_ffff : 18'(rnd());
      d = d >> (j % 3);
      wr(4'(SCB_ADDR_RF1 + j % 3), d, 22);
      check();
    end
    $display("test dividers done");
    // Mid-run reset brings every register back to its value after reset
    #1 rst_b_i = 1'b0;
    repeat (2) @(posedge clk_sys_i);
    #1 rst_b_i = 1'b1;
    m_main = 32'h0000_1000;
    m_pdn  = 0;
    m_div  = '{0, 0, 0};
    repeat (2) @(posedge clk_sys_i);
    check();
    $display("test mid-run reset done");
    // Unmapped addresses and a short word change nothing
    for (int a = 1; a < 16; a++) begin
      if (a == 1 || a > 5) begin
        wr(4'(a), 18'(rnd()), 22);
        check();
      end
    end
    wr(SCB_ADDR_RF1, 18'(rnd()), 21);
    check();
    $display("test refused writes done");
    summarize();
  end

  // Verdict
  task automatic summarize();
    $display("checks %0d mismatches %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
endmodule
